// File: design/prs_por_seq.sv
// Power-on reset sequencer with AHB-Lite control and status registers
//
// Operation
// - Start configuration copy when core supply passes its start threshold.
// - Keep all I/O tri-stated with pull-ups before and during the copy.
// - Finish copy and user-mode entry within the configuration time.
// - Wait for all bank supplies; enter user mode 2 us after late banks.
// - On user-mode entry hand I/O pins to user logic.
// - Outside low-power variant, core sag to 1.4 V resets SRAM, tri-states I/O.
// - After brown-out, restart copy when core supply recovers.
// - Low-power variant stops all supply monitoring once in user mode.
// - Clear and release user registers before releasing I/O tri-states.
// - With clear pin enabled, clears hold until the pin is deasserted.
// - With output-enable pin enabled, I/O stays tri-stated until pin asserted.
// - Outside low-power user mode, supply-low guard forces output buffers off while any supply is low.
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module prs_por_seq #(
  parameter logic [16:0] CFG_CYC = 17'(prs_pkg::CFG_TIME_CYC)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic core_start_ok,
  input wire logic core_above_sag,
  input wire logic [3:0] bank_good,
  input wire logic global_register_clear_pin_n,
  input wire logic global_output_enable_pin,
  output logic cfg_copy_start,
  output logic cfg_copy_busy,
  output logic sram_reset,
  output logic user_reg_clear,
  output logic io_tristate,
  output logic io_pullup_en,
  output logic supply_low_guard,
  output logic user_mode,
  output logic irq
);
  localparam logic [16:0] COPY_END = CFG_CYC - 17'(prs_pkg::SEQ_OVH_CYC);
  localparam logic [16:0] BANK_END = 17'(prs_pkg::BANK_DLY_CYC - 1);

  typedef struct packed {
    prs_pkg::prs_state_t state;
    logic [prs_pkg::CNT_W-1:0] cnt;
    logic [prs_pkg::CTRL_W-1:0] ctrl;
    logic [prs_pkg::INT_W-1:0] int_stat;
    logic [prs_pkg::INT_W-1:0] int_mask;
    logic [31:0] rdata;
    logic a_valid;
    logic a_wr;
    logic [prs_pkg::ADDR_W-1:0] a_addr;
    logic guard;
    logic copy_pulse;
  } prs_top_st_t;

  prs_top_st_t st_r;
  prs_top_st_t st_nxt;

  logic [prs_pkg::SYNC_W-1:0] flags_s;
  logic core_s;
  logic sag_s;
  logic [3:0] bank_s;
  logic bank_all;
  logic lowpwr;
  logic clr_en;
  logic oe_en;
  logic oe_hold;
  logic pre_user;
  logic monitor_off;

  // Comparator flags are asynchronous to the clock
  prs_sync #(
    .W(prs_pkg::SYNC_W)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({bank_good, core_above_sag, core_start_ok}),
    .q(flags_s)
  );

  assign core_s = flags_s[0];
  assign sag_s = flags_s[1];
  assign bank_s = flags_s[prs_pkg::SYNC_W-1:2];
  assign bank_all = &bank_s;
  assign lowpwr = st_r.ctrl[prs_pkg::CTRL_LOWPWR];
  assign clr_en = st_r.ctrl[prs_pkg::CTRL_CLR_EN];
  assign oe_en = st_r.ctrl[prs_pkg::CTRL_OE_EN];
  assign monitor_off = (st_r.state == prs_pkg::PRS_USER) && lowpwr;

  always_comb begin
    logic [prs_pkg::INT_W-1:0] ev;
    logic [prs_pkg::INT_W-1:0] w1c;
    logic [31:0] rd;
    ev = '0;
    w1c = '0;
    rd = '0;
    st_nxt = st_r;
    st_nxt.copy_pulse = 1'b0;

    // Sequencer
    unique case (st_r.state)
      prs_pkg::PRS_OFF: begin
        if (core_s && sag_s) begin
          st_nxt.state = prs_pkg::PRS_COPY;
          st_nxt.cnt = '0;
          st_nxt.copy_pulse = 1'b1;
        end
      end
      prs_pkg::PRS_COPY: begin
        st_nxt.cnt = st_r.cnt + 17'h00001;
        if (st_r.cnt >= COPY_END) begin
          if (bank_all) begin
            st_nxt.state = prs_pkg::PRS_CLEAR;
          end else begin
            st_nxt.state = prs_pkg::PRS_BANK_WAIT;
            ev[prs_pkg::INT_LATE] = 1'b1;
          end
        end
      end
      prs_pkg::PRS_BANK_WAIT: begin
        if (bank_all) begin
          st_nxt.state = prs_pkg::PRS_BANK_DLY;
          st_nxt.cnt = '0;
        end
      end
      prs_pkg::PRS_BANK_DLY: begin
        st_nxt.cnt = st_r.cnt + 17'h00001;
        if (!bank_all) begin
          st_nxt.state = prs_pkg::PRS_BANK_WAIT;
        end else if (st_r.cnt >= BANK_END) begin
          st_nxt.state = prs_pkg::PRS_CLEAR;
        end
      end
      prs_pkg::PRS_CLEAR: begin
        // One cycle with clears released and pins still tri-stated
        st_nxt.state = prs_pkg::PRS_USER;
        ev[prs_pkg::INT_USER] = 1'b1;
      end
      prs_pkg::PRS_USER: begin
      end
      default: begin
        st_nxt.state = prs_pkg::PRS_OFF;
      end
    endcase

    // Core sag aborts any phase, except once the low-power part is running
    if (st_r.state != prs_pkg::PRS_OFF && !sag_s && !monitor_off) begin
      st_nxt.state = prs_pkg::PRS_OFF;
      st_nxt.cnt = '0;
      st_nxt.copy_pulse = 1'b0;
      ev[prs_pkg::INT_USER] = 1'b0;
      ev[prs_pkg::INT_BROWN] = (st_r.state == prs_pkg::PRS_USER);
    end

    // Guard watches core and every bank until monitoring stops
    st_nxt.guard = !(sag_s && bank_all) && !monitor_off;

    // Bus data phase: write
    if (st_r.a_valid && st_r.a_wr) begin
      unique case (st_r.a_addr)
        prs_pkg::REG_CTRL: st_nxt.ctrl = hwdata[prs_pkg::CTRL_W-1:0];
        prs_pkg::REG_INT_STAT: w1c = hwdata[prs_pkg::INT_W-1:0];
        prs_pkg::REG_INT_MASK: st_nxt.int_mask = hwdata[prs_pkg::INT_W-1:0];
        default: begin
        end
      endcase
    end
    // A new event wins over its own clear
    st_nxt.int_stat = (st_r.int_stat & ~w1c) | ev;

    // Bus address phase
    st_nxt.a_valid = hsel && hready && htrans[1];
    if (hsel && hready) begin
      st_nxt.a_wr = hwrite;
      st_nxt.a_addr = haddr[prs_pkg::ADDR_W-1:0];
    end
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[prs_pkg::ADDR_W-1:0])
        prs_pkg::REG_CTRL: rd[prs_pkg::CTRL_W-1:0] = st_r.ctrl;
        prs_pkg::REG_STATUS: begin
          rd[prs_pkg::ST_STATE_LSB +: 3] = st_r.state;
          rd[prs_pkg::ST_USER] = (st_r.state == prs_pkg::PRS_USER);
          rd[prs_pkg::ST_CORE] = core_s;
          rd[prs_pkg::ST_SAG] = sag_s;
          rd[prs_pkg::ST_BANK_LSB +: prs_pkg::NBANK] = bank_s;
          rd[prs_pkg::ST_GUARD] = st_r.guard;
        end
        prs_pkg::REG_INT_STAT: rd[prs_pkg::INT_W-1:0] = st_r.int_stat;
        prs_pkg::REG_INT_MASK: rd[prs_pkg::INT_W-1:0] = st_r.int_mask;
        default: rd = '0;
      endcase
      st_nxt.rdata = rd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.state <= prs_pkg::PRS_OFF;
      st_r.cnt <= '0;
      st_r.ctrl <= prs_pkg::CTRL_RST;
      st_r.int_stat <= prs_pkg::INT_RST;
      st_r.int_mask <= prs_pkg::INT_RST;
      st_r.rdata <= '0;
      st_r.a_valid <= 1'b0;
      st_r.a_wr <= 1'b0;
      st_r.a_addr <= '0;
      st_r.guard <= 1'b1;
      st_r.copy_pulse <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Zero wait states; a read returns values sampled at its address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;

  assign pre_user = (st_r.state != prs_pkg::PRS_USER) && (st_r.state != prs_pkg::PRS_CLEAR);
  assign oe_hold = oe_en && !global_output_enable_pin;

  assign cfg_copy_start = st_r.copy_pulse;
  assign cfg_copy_busy = (st_r.state == prs_pkg::PRS_COPY);
  assign sram_reset = (st_r.state == prs_pkg::PRS_OFF);
  assign user_mode = (st_r.state == prs_pkg::PRS_USER);
  // Clears drop one cycle ahead of the pins unless the clear pin holds them
  assign user_reg_clear = pre_user || (clr_en && !global_register_clear_pin_n);
  assign io_tristate = !user_mode || oe_hold || st_r.guard;
  assign io_pullup_en = !user_mode;
  assign supply_low_guard = st_r.guard;
  assign irq = |(st_r.int_stat & st_r.int_mask);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_copy_start: assert property (
    (st_r.state == prs_pkg::PRS_OFF && core_s && sag_s)
      |=> (st_r.state == prs_pkg::PRS_COPY && cfg_copy_start && st_r.cnt == '0)
  ) else $error("copy did not start at threshold");

  chk_io_held: assert property (
    (st_r.state != prs_pkg::PRS_USER) |-> (io_tristate && io_pullup_en)
  ) else $error("I/O released before user mode");

  chk_cfg_time: assert property (
    (st_r.state == prs_pkg::PRS_COPY && st_r.cnt == COPY_END && bank_all && sag_s)
      |=> (st_r.state == prs_pkg::PRS_CLEAR) ##1 (st_r.state == prs_pkg::PRS_USER)
  ) else $error("user mode not reached at configuration time");

  chk_bank_delay: assert property (
    (st_r.state == prs_pkg::PRS_BANK_WAIT && bank_all && sag_s)
      |=> (st_r.state == prs_pkg::PRS_BANK_DLY && st_r.cnt == '0)
  ) else $error("bank delay did not start");

  chk_bank_gate: assert property (
    $rose(user_mode) |-> $past(bank_all, 2)
  ) else $error("user mode entered with a bank supply low");

  chk_user_release: assert property (
    (user_mode && !st_r.guard && !oe_hold) |-> !io_tristate
  ) else $error("I/O not handed to user logic");

  chk_brownout: assert property (
    (user_mode && !lowpwr && !sag_s) |=> (sram_reset && io_tristate && !user_mode)
  ) else $error("brown-out not acted on");

  chk_lowpwr_hold: assert property (
    (user_mode && lowpwr) |=> user_mode
  ) else $error("low-power variant left user mode");

  chk_clear_order: assert property (
    (st_r.state == prs_pkg::PRS_CLEAR && !clr_en) |-> (!user_reg_clear && io_tristate)
  ) else $error("clear not released before tri-state release");

  chk_clear_pin: assert property (
    (!pre_user && clr_en && !global_register_clear_pin_n) |-> user_reg_clear
  ) else $error("clear pin ignored");

  chk_oe_pin: assert property (
    (oe_en && !global_output_enable_pin) |-> io_tristate
  ) else $error("output-enable pin ignored");

  chk_guard_low: assert property (
    (!sag_s && !monitor_off) |=> supply_low_guard
  ) else $error("guard not raised on low supply");

  chk_pulse_once: assert property (
    cfg_copy_start |=> !cfg_copy_start
  ) else $error("copy start longer than one cycle");

  chk_copy_pins: assert property (
    cfg_copy_busy |-> (io_tristate && io_pullup_en && user_reg_clear)
  ) else $error("I/O or registers released during copy");

  chk_copy_bound: assert property (
    (st_r.state == prs_pkg::PRS_COPY) |-> (st_r.cnt <= COPY_END)
  ) else $error("copy ran past its count");

  chk_late_event: assert property (
    (st_r.state == prs_pkg::PRS_COPY && st_r.cnt >= COPY_END && !bank_all && sag_s)
      |=> (st_r.state == prs_pkg::PRS_BANK_WAIT && st_r.int_stat[prs_pkg::INT_LATE])
  ) else $error("late banks not waited for");

  chk_bank_end: assert property (
    (st_r.state == prs_pkg::PRS_BANK_DLY && st_r.cnt == BANK_END && bank_all && sag_s)
      |=> (st_r.state == prs_pkg::PRS_CLEAR)
  ) else $error("bank delay did not end on time");

  chk_brown_event: assert property (
    (user_mode && !lowpwr && !sag_s) |=> st_r.int_stat[prs_pkg::INT_BROWN]
  ) else $error("brown-out event not recorded");

  chk_copy_restart: assert property (
    (sram_reset && core_s && sag_s) |=> cfg_copy_start
  ) else $error("copy not restarted after recovery");

  chk_guard_off: assert property (
    (user_mode && lowpwr) |=> !supply_low_guard
  ) else $error("low-power variant still watches supplies");

  chk_user_clear: assert property (
    (user_mode && !(clr_en && !global_register_clear_pin_n)) |-> !user_reg_clear
  ) else $error("register clear held in user mode");

  // Main paths: first entry, late banks, brown-out, low-power hold and pin-held outputs
  cov_user: cover property ($rose(user_mode));
  cov_late: cover property ((st_r.state == prs_pkg::PRS_BANK_DLY) ##1 (st_r.state == prs_pkg::PRS_CLEAR));
  cov_brown: cover property (user_mode ##1 sram_reset ##[1:20] cfg_copy_start);
  cov_lowpwr: cover property (user_mode && lowpwr && !sag_s);
  cov_oe_hold: cover property ((user_mode && oe_hold) ##1 (user_mode && !io_tristate));
endmodule // prs_por_seq

// File: design/prs_sync.sv
// Shared constants and the supply-flag synchroniser of the power-on reset sequencer
`timescale 1ns/10ps
package prs_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PS_PER_US = 1000000;
  localparam int CFG_TIME_US = 450;
  localparam int BANK_DLY_US = 2;
  // Longest time rounds down
  localparam int CFG_TIME_CYC = CFG_TIME_US * PS_PER_US / CLK_PERIOD_PS;
  // Least time rounds up
  localparam int BANK_DLY_CYC = (BANK_DLY_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Cycles spent outside the copy count: sync, start, clear step, margin
  localparam int SEQ_OVH_CYC = 6;
  localparam int CNT_W = 17;
  localparam int NBANK = 4;
  localparam int SYNC_W = NBANK + 2;
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0c;
  // Control fields
  localparam int CTRL_W = 3;
  localparam int CTRL_CLR_EN = 0;
  localparam int CTRL_OE_EN = 1;
  localparam int CTRL_LOWPWR = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // Interrupt fields
  localparam int INT_W = 3;
  localparam int INT_USER = 0;
  localparam int INT_BROWN = 1;
  localparam int INT_LATE = 2;
  localparam logic [2:0] INT_RST = 3'h0;
  // Status fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_USER = 3;
  localparam int ST_CORE = 4;
  localparam int ST_SAG = 5;
  localparam int ST_BANK_LSB = 6;
  localparam int ST_GUARD = 10;
  typedef enum logic [2:0] {
    PRS_OFF, PRS_COPY, PRS_BANK_WAIT, PRS_BANK_DLY, PRS_CLEAR, PRS_USER
  } prs_state_t;
endpackage

module prs_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } prs_sync_st_t;
  prs_sync_st_t st_r;
  prs_sync_st_t st_nxt;

  // First stage feeds only the second
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule // prs_sync

// File: verif/power_on_reset_sequencer_tb.sv
// Self-checking testbench of the power-on reset sequencer
`timescale 1ns/10ps
module power_on_reset_sequencer_tb;
  localparam int CFG = 64;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, rd;
  logic core_on = 1'b0;
  logic core_sag = 1'b0;
  logic [3:0] bank_on = 4'h0;
  logic clr_n = 1'b1;
  logic oe_pin = 1'b1;
  logic core_start_ok, core_above_sag;
  logic [3:0] bank_good;
  logic cfg_copy_start, cfg_copy_busy, sram_reset, user_reg_clear;
  logic io_tristate, io_pullup_en, supply_low_guard, user_mode, irq;
  int num_errors = 0;
  int comparisons = 0;
  int n, s, b;
  logic ok, c, t;

  always #2 hclk = ~hclk;

  prs_por_seq #(.CFG_CYC(17'(CFG))) i_prs_por_seq (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_start_ok(core_start_ok),
    .core_above_sag(core_above_sag), .bank_good(bank_good), .global_register_clear_pin_n(clr_n),
    .global_output_enable_pin(oe_pin), .cfg_copy_start(cfg_copy_start), .cfg_copy_busy(cfg_copy_busy),
    .sram_reset(sram_reset), .user_reg_clear(user_reg_clear), .io_tristate(io_tristate),
    .io_pullup_en(io_pullup_en), .supply_low_guard(supply_low_guard), .user_mode(user_mode), .irq(irq));

  prs_supply_model i_prs_supply_model (.hclk(hclk), .core_on(core_on), .core_sag(core_sag), .bank_on(bank_on),
    .core_start_ok(core_start_ok), .core_above_sag(core_above_sag), .bank_good(bank_good));

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask

  // Single word transfer; waits on the slave's own ready, the watchdog bounds it
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("bus response", hresp, 0);
    chk("bus ready", hreadyout, 1);
    tick(2);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    tick(1);
  endtask

  // Counts cycles to user mode and watches the pins on the way
  task automatic wait_user();
    n = 0;
    s = 0;
    b = 0;
    ok = 1'b1;
    while (user_mode !== 1'b1 && n < 4000) begin
      ok = ok & (io_tristate === 1'b1) & (io_pullup_en === 1'b1);
      c = user_reg_clear;
      t = io_tristate;
      s += (cfg_copy_start === 1'b1);
      b += (cfg_copy_busy === 1'b1);
      tick(1);
      n++;
    end
  endtask

  task automatic power_up();
    while (core_start_ok !== 1'b1) tick(1);
    wait_user();
    chk("copy start pulses", s, 1);
    chk("tristate and pullup before user", ok, 1);
    chk("user within config time", n <= CFG, 1);
    chk("copy busy cycles", b, CFG - prs_pkg::SEQ_OVH_CYC + 1);
    chk("sram reset off in user", sram_reset, 0);
    chk("clears released first", c, 0);
    chk("tristate while clears released", t, 1);
    chk("io released in user", io_tristate, 0);
    chk("pullups off in user", io_pullup_en, 0);
  endtask

  task automatic t_up();
    chk("tristate after reset", io_tristate, 1);
    chk("guard after reset", supply_low_guard, 1);
    chk("busy after reset", cfg_copy_busy, 0);
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped read", rd, 32'h0);
    bank_on <= 4'hf;
    core_on <= 1'b1;
    power_up();
    bus(1'b0, 8'h08, 32'h0);
    chk("user event", rd[0], 1);
    chk("irq masked", irq, 0);
    bus(1'b1, 8'h0c, 32'h7);
    chk("irq unmasked", irq, 1);
    bus(1'b1, 8'h08, 32'h7);
    chk("irq cleared", irq, 0);
  endtask

  task automatic t_brown();
    core_sag <= 1'b1;
    tick(8);
    chk("user left on sag", user_mode, 0);
    chk("sram reset on sag", sram_reset, 1);
    chk("io tristate on sag", io_tristate, 1);
    chk("brown-out irq", irq, 1);
    bus(1'b1, 8'h08, 32'h7);
    core_sag <= 1'b0;
    power_up();
  endtask

  task automatic t_guard();
    bank_on <= 4'h7;
    tick(6);
    chk("guard on bank low", supply_low_guard, 1);
    chk("io off on bank low", io_tristate, 1);
    chk("banks not watched in user", user_mode, 1);
    bus(1'b0, 8'h04, 32'h0);
    chk("status on bank low", rd, 32'h5fd);
    bank_on <= 4'hf;
    tick(6);
    chk("guard off", supply_low_guard, 0);
  endtask

  task automatic t_pins();
    bus(1'b1, 8'h00, 32'h3);
    clr_n <= 1'b0;
    oe_pin <= 1'b0;
    tick(2);
    chk("clear held by pin", user_reg_clear, 1);
    chk("io held by oe pin", io_tristate, 1);
    oe_pin <= 1'b1;
    tick(2);
    chk("io released by oe pin", io_tristate, 0);
    chk("clear outlasts tristate", user_reg_clear, 1);
    clr_n <= 1'b1;
    tick(2);
    chk("clear released by pin", user_reg_clear, 0);
    bus(1'b1, 8'h00, 32'h0);
  endtask

  task automatic t_late();
    bank_on <= 4'h0;
    do_reset();
    tick(CFG + 20);
    chk("user waits for banks", user_mode, 0);
    bus(1'b0, 8'h08, 32'h0);
    chk("banks late event", rd[2], 1);
    bank_on <= 4'hf;
    wait_user();
    chk("bank delay", n >= 500 && n <= 508, 1);
  endtask

  task automatic t_lowpwr();
    bus(1'b1, 8'h00, 32'h4);
    core_on <= 1'b0;
    tick(10);
    chk("no brown-out reset", user_mode, 1);
    chk("no supply guard", supply_low_guard, 0);
    core_on <= 1'b1;
    do_reset();
    power_up();
  endtask

  initial begin
    do_reset();
    t_up();
    t_brown();
    t_guard();
    t_pins();
    t_late();
    t_lowpwr();
    results();
  end

  // Whole run needs some 3500 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    results();
  end
endmodule // power_on_reset_sequencer_tb

// File: verif/prs_supply_model.sv
// Board supply model: core rail ramp, brown-out sag and bank rails
`timescale 1ns/10ps
module prs_supply_model #(
  parameter int HOLD_CYC = 2500
) (
  input wire logic hclk,
  input wire logic core_on,
  input wire logic core_sag,
  input wire logic [3:0] bank_on,
  output logic core_start_ok,
  output logic core_above_sag,
  output logic [3:0] bank_good
);
  // Rail level: 0 off, 1 sagged, 2 above sag, 3 at start threshold
  int lvl = 0;
  int off_cnt = HOLD_CYC;
  int tgt;
  assign tgt = !core_on ? 0 : (core_sag ? 1 : 3);
  always @(posedge hclk) begin
    off_cnt <= (lvl == 0) ? off_cnt + 1 : 0;
    // Rail is held at 0 V for the full hold time before it is re-applied
    if (lvl < tgt && (lvl > 0 || off_cnt >= HOLD_CYC)) lvl <= lvl + 1;
    else if (lvl > tgt) lvl <= lvl - 1;
  end
  assign core_start_ok = (lvl >= 3);
  assign core_above_sag = (lvl >= 2);
  assign bank_good = bank_on;
endmodule // prs_supply_model
